/* File: shared/mpra_pkg.sv */
// package: command codes, mode bits, page defaults for the multipurpose access block
package mpra_pkg;
  // command encodings on the link
  typedef enum logic [3:0] {
    MPRA_CMD_DES,
    MPRA_CMD_MRS,
    MPRA_CMD_RD,
    MPRA_CMD_RDA,
    MPRA_CMD_WR,
    MPRA_CMD_WRA,
    MPRA_CMD_REF,
    MPRA_CMD_ACT,
    MPRA_CMD_PRE,
    MPRA_CMD_SRE,
    MPRA_CMD_PDE
  } mpra_cmd_t;
  // mode register 3 fields
  localparam int MPRA_MR3_IDX = 3;
  localparam int MPRA_MR3_EN_BIT = 2;
  localparam int MPRA_MR3_PAGE_LSB = 0;
  localparam int MPRA_MR3_FMT_LSB = 11;
  localparam logic [1:0] MPRA_FMT_SERIAL = 2'h0;
  localparam logic [1:0] MPRA_FMT_PARALLEL = 2'h1;
  localparam logic [1:0] MPRA_FMT_STAGGER = 2'h2;
  // burst selection through low address bits
  localparam logic [2:0] MPRA_BL8_CODE = 3'h0;
  localparam logic [2:0] MPRA_BC4_CODE = 3'h4;
  localparam int MPRA_BEATS_BL8 = 8;
  localparam int MPRA_BEATS_BC4 = 4;
  // page 0 power-up patterns, bit 7 first on the wire
  localparam logic [7:0] MPRA_P0_L0 = 8'h55;
  localparam logic [7:0] MPRA_P0_L1 = 8'h33;
  localparam logic [7:0] MPRA_P0_L2 = 8'h0F;
  localparam logic [7:0] MPRA_P0_L3 = 8'h00;
  localparam logic [7:0] MPRA_MR_RESET = 8'h00;
  // apb register offsets of the controller
  localparam logic [7:0] MPRA_OFF_CMD = 8'h00;
  localparam logic [7:0] MPRA_OFF_ADDR = 8'h04;
  localparam logic [7:0] MPRA_OFF_STAT = 8'h08;
  localparam logic [7:0] MPRA_OFF_RDATA = 8'h0C;
  localparam logic [31:0] MPRA_REG_RESET = 32'h0000_0000;
  // refresh cycle time in cycles the controller waits
  localparam int MPRA_TRFC_CYC = 16;
endpackage : mpra_pkg

/* File: shared/mpra_if.sv */
// interface: command link and data bus between controller and device
`timescale 1ns/100ps
interface mpra_if;
  import mpra_pkg::*;
  logic cmd_vld;
  mpra_cmd_t cmd;
  logic [17:0] addr;
  logic [1:0] ba;
  logic [7:0] wdata;
  logic dbi_en;
  logic [7:0] dq;
  logic dq_vld;
  logic dq_last;
  modport dev (input cmd_vld, cmd, addr, ba, wdata, dbi_en, output dq, dq_vld, dq_last);
  modport ctl (output cmd_vld, cmd, addr, ba, wdata, dbi_en, input dq, dq_vld, dq_last);
endinterface : mpra_if

/* File: logic/mpra_dev.sv */
// device end: multipurpose storage pages, mode registers and read-out serialiser
`timescale 1ns/100ps
module mpra_dev import mpra_pkg::*; (
  input wire logic CORE_CLK, // command clock
  input wire logic RESET, // async reset, high
  mpra_if.dev LINK, // command and data link
  input wire logic [7:0] PAR_LOG [4], // captured parity error frame
  output logic MODE_ON, // multipurpose mode active
  output logic ARRAY_RD, // normal array read pulse
  output logic ARRAY_WR, // normal array write pulse
  output logic ARRAY_AP // auto precharge with array access
);
  typedef struct packed {
    logic [3:0][7:0] mr; // mode registers 0..3 low bytes
    logic [1:0] mr3_fmt;
    logic [3:0][7:0] p0;
    logic [7:0] shreg;
    logic [3:0] beats;
    logic [7:0] dq;
    logic dq_vld;
    logic dq_last;
    logic arr_rd;
    logic arr_wr;
    logic arr_ap;
  } mpra_dev_st_t;
  mpra_dev_st_t st_r, st_nxt;
  logic en;
  logic [1:0] page;
  logic [7:0] loc_byte;

  assign en = st_r.mr[MPRA_MR3_IDX][MPRA_MR3_EN_BIT];
  assign page = st_r.mr[MPRA_MR3_IDX][MPRA_MR3_PAGE_LSB +: 2];

  // location lookup per page
  always_comb begin
    loc_byte = 8'h00;
    case (page)
      2'h0: loc_byte = st_r.p0[LINK.ba];
      2'h1: loc_byte = PAR_LOG[LINK.ba];
      // register readback, lower half then upper half by A0
      2'h2: loc_byte = LINK.addr[0] ? {4'h0, st_r.mr[LINK.ba][7:4]} : {4'h0, st_r.mr[LINK.ba][3:0]};
      default: loc_byte = 8'h00; // reserved page
    endcase
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.arr_rd = 1'b0;
    st_nxt.arr_wr = 1'b0;
    st_nxt.arr_ap = 1'b0;
    st_nxt.dq_last = 1'b0;
    // burst shifting, bit 7 on first beat
    if (st_r.beats != 4'h0) begin
      st_nxt.beats = st_r.beats - 4'h1;
      // parallel format repeats bit across lanes on page 0 only
      if (page == 2'h0 && st_r.mr3_fmt == MPRA_FMT_PARALLEL) begin
        st_nxt.dq = {8{st_r.shreg[7]}};
      end else if (page == 2'h0 && st_r.mr3_fmt == MPRA_FMT_STAGGER) begin
        st_nxt.dq = {st_r.shreg[7], st_r.shreg[6:0]};
      end else begin
        st_nxt.dq = {7'h00, st_r.shreg[7]};
      end
      st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
      st_nxt.dq_vld = 1'b1;
      st_nxt.dq_last = (st_r.beats == 4'h1);
    end else begin
      st_nxt.dq_vld = 1'b0;
      st_nxt.dq = 8'h00;
    end
    if (LINK.cmd_vld) begin
      case (LINK.cmd)
        MPRA_CMD_MRS: begin
          st_nxt.mr[LINK.ba] = LINK.addr[7:0];
          if (LINK.ba == 2'(MPRA_MR3_IDX)) st_nxt.mr3_fmt = LINK.addr[MPRA_MR3_FMT_LSB +: 2];
        end
        MPRA_CMD_RD, MPRA_CMD_RDA: begin
          if (en) begin
            st_nxt.shreg = loc_byte;
            // chop four by 100, else eight
            st_nxt.beats = (LINK.addr[2:0] == MPRA_BC4_CODE) ? 4'(MPRA_BEATS_BC4) : 4'(MPRA_BEATS_BL8);
          end else begin
            st_nxt.arr_rd = 1'b1;
            st_nxt.arr_ap = (LINK.cmd == MPRA_CMD_RDA);
          end
        end
        MPRA_CMD_WR, MPRA_CMD_WRA: begin
          if (en) begin
            if (page == 2'h0) st_nxt.p0[LINK.ba] = LINK.wdata;
          end else begin
            st_nxt.arr_wr = 1'b1;
            st_nxt.arr_ap = (LINK.cmd == MPRA_CMD_WRA);
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      st_r <= '0;
      st_r.p0 <= {MPRA_P0_L3, MPRA_P0_L2, MPRA_P0_L1, MPRA_P0_L0};
      st_r.mr <= {4{MPRA_MR_RESET}};
      st_r.mr3_fmt <= MPRA_FMT_SERIAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign LINK.dq = st_r.dq;
  assign LINK.dq_vld = st_r.dq_vld;
  assign LINK.dq_last = st_r.dq_last;
  assign MODE_ON = en;
  assign ARRAY_RD = st_r.arr_rd;
  assign ARRAY_WR = st_r.arr_wr;
  assign ARRAY_AP = st_r.arr_ap;
endmodule : mpra_dev

/* File: logic/mpra_ctl.sv */
// controller end: apb slave that issues link commands and gathers read bursts
`timescale 1ns/100ps
module mpra_ctl import mpra_pkg::*; (
  input wire logic CORE_CLK, // command clock
  input wire logic RESET, // async reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  mpra_if.ctl LINK // command and data link
);
  typedef struct packed {
    logic [17:0] addr;
    logic [1:0] ba;
    logic [7:0] wdata;
    logic cmd_vld;
    mpra_cmd_t cmd;
    logic mode_on;
    logic [7:0] rdata;
    logic [7:0] wait_cnt; // refresh hold-off
    logic busy; // read burst outstanding
    logic err; // refused command
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mpra_ctl_st_t;
  mpra_ctl_st_t st_r, st_nxt;
  logic acc;
  mpra_cmd_t req;

  assign acc = PSEL && PENABLE && !st_r.pready;
  assign req = mpra_cmd_t'(PWDATA[3:0]);

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd_vld = 1'b0;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (st_r.wait_cnt != 8'h00) st_nxt.wait_cnt = st_r.wait_cnt - 8'h01;
    // gather burst serially, bit 7 arrives first
    if (LINK.dq_vld) st_nxt.rdata = {st_r.rdata[6:0], LINK.dq[0]};
    if (LINK.dq_last) st_nxt.busy = 1'b0;
    if (acc) begin
      st_nxt.pready = 1'b1;
      if (PWRITE) begin
        if (PADDR == MPRA_OFF_ADDR) begin
          st_nxt.addr = PWDATA[17:0];
          st_nxt.ba = PWDATA[21:20];
          st_nxt.wdata = PWDATA[31:24];
        end else if (PADDR == MPRA_OFF_CMD) begin
          // hold during refresh; no refresh mid read
          if (st_r.wait_cnt != 8'h00 || (st_r.busy && req == MPRA_CMD_REF)) begin
            st_nxt.err = 1'b1;
          // only allowed commands in mode; precharge is host duty
          end else if (st_r.mode_on && (req == MPRA_CMD_ACT || req == MPRA_CMD_SRE || req == MPRA_CMD_PDE
                       || req == MPRA_CMD_PRE)) begin
            st_nxt.err = 1'b1;
          end else if (st_r.mode_on && (req == MPRA_CMD_RD || req == MPRA_CMD_RDA)
                       && st_r.addr[2:0] != MPRA_BL8_CODE && st_r.addr[2:0] != MPRA_BC4_CODE) begin
            st_nxt.err = 1'b1;
          end else begin
            st_nxt.cmd_vld = 1'b1;
            st_nxt.cmd = req;
            st_nxt.err = 1'b0;
            if (req == MPRA_CMD_MRS && st_r.ba == 2'(MPRA_MR3_IDX))
              st_nxt.mode_on = st_r.addr[MPRA_MR3_EN_BIT];
            if (req == MPRA_CMD_REF) st_nxt.wait_cnt = 8'(MPRA_TRFC_CYC);
            if (req == MPRA_CMD_RD || req == MPRA_CMD_RDA) st_nxt.busy = st_r.mode_on;
          end
        end else begin
          st_nxt.pslverr = 1'b1;
        end
      end else begin
        if (PADDR == MPRA_OFF_STAT) st_nxt.prdata = {28'h0000000, (st_r.wait_cnt != 8'h00), st_r.err,
                                                     st_r.busy, st_r.mode_on};
        else if (PADDR == MPRA_OFF_RDATA) st_nxt.prdata = {24'h000000, st_r.rdata};
        else if (PADDR == MPRA_OFF_ADDR) st_nxt.prdata = {st_r.wdata, 2'h0, st_r.ba, 2'h0, st_r.addr};
        else if (PADDR != MPRA_OFF_CMD) st_nxt.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign LINK.cmd_vld = st_r.cmd_vld;
  assign LINK.cmd = st_r.cmd;
  assign LINK.addr = st_r.addr;
  assign LINK.ba = st_r.ba;
  assign LINK.wdata = st_r.wdata;
  assign LINK.dbi_en = 1'b0;
endmodule : mpra_ctl

/* File: verification/mpra_properties.sv */
// checker: link timing and command rules between controller and device
`timescale 1ns/100ps
module mpra_properties import mpra_pkg::*; (
  input wire logic CORE_CLK, // command clock
  input wire logic RESET, // async reset
  input wire logic cmd_vld, // command strobe
  input wire mpra_cmd_t cmd, // command code
  input wire logic [17:0] addr, // command address
  input wire logic [1:0] ba, // bank address
  input wire logic dbi_en, // bus inversion
  input wire logic dq_vld, // beat strobe
  input wire logic dq_last // final beat
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic mode_r;
  logic [4:0] gap_r;
  wire rd_c = cmd_vld && (cmd == MPRA_CMD_RD || cmd == MPRA_CMD_RDA);
  // mode mirrored from mr3 writes; refresh gap counted down
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      mode_r <= 1'b0;
      gap_r <= 5'h00;
    end else begin
      if (cmd_vld && cmd == MPRA_CMD_MRS && ba == 2'h3)
        mode_r <= addr[MPRA_MR3_EN_BIT];
      if (cmd_vld && cmd == MPRA_CMD_REF)
        gap_r <= 5'(MPRA_TRFC_CYC - 1);
      else if (gap_r != 5'h00)
        gap_r <= gap_r - 5'h01;
    end
  end
  // read steps: command taken, then a run of beats
  sequence s_bl8; rd_c && mode_r && addr[2:0] == MPRA_BL8_CODE; endsequence
  sequence s_bc4; rd_c && mode_r && addr[2:0] == MPRA_BC4_CODE; endsequence
  sequence s_tail; dq_vld && dq_last; endsequence
  AST_NO_DBI: assert property (!dbi_en) else $error("bus inversion on");
  // first beat shows two edges after the read is taken: device loads, then shifts
  AST_BL8: assert property (s_bl8 |=> ##1 (dq_vld && !dq_last) [*7] ##1 s_tail)
    else $error("eight beat burst wrong");
  AST_BC4: assert property (s_bc4 |=> ##1 (dq_vld && !dq_last) [*3] ##1 s_tail)
    else $error("four beat burst wrong");
  AST_LAST: assert property (dq_last |-> dq_vld) else $error("last without beat");
  AST_NO_STRAY: assert property ($rose(dq_vld) |-> $past(rd_c, 2)) else $error("burst without read");
  AST_ALLOWED: assert property (cmd_vld && mode_r |->
    cmd inside {MPRA_CMD_DES, MPRA_CMD_MRS, MPRA_CMD_RD, MPRA_CMD_RDA, MPRA_CMD_WR, MPRA_CMD_WRA, MPRA_CMD_REF})
    else $error("command not allowed in mode");
  AST_NO_SR_PD: assert property (mode_r |-> !(cmd_vld && cmd inside {MPRA_CMD_SRE, MPRA_CMD_PDE}))
    else $error("power down in mode");
  AST_REF_GAP: assert property (gap_r != 5'h00 |-> !cmd_vld) else $error("command inside refresh");
endmodule : mpra_properties

/* File: verification/tb_top.sv */
// testbench: apb driven controller facing the device across the link
`timescale 1ns/100ps
module tb_top import mpra_pkg::*; ;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err_q, mode_on, array_rd, array_wr, array_ap;
  logic [7:0] par_log [4] = '{8'hC3, 8'h5A, 8'h81, 8'h7E};
  logic [7:0] p0 [4] = '{MPRA_P0_L0, MPRA_P0_L1, MPRA_P0_L2, MPRA_P0_L3};
  int mismatches = 0;
  int comparisons = 0;
  int arr_hits = 0;
  int ap_hits = 0;
  mpra_if link();
  mpra_dev u_mpra_dev (.CORE_CLK(core_clk), .RESET(reset), .LINK(link.dev), .PAR_LOG(par_log),
    .MODE_ON(mode_on), .ARRAY_RD(array_rd), .ARRAY_WR(array_wr), .ARRAY_AP(array_ap));
  mpra_ctl u_mpra_ctl (.CORE_CLK(core_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK(link.ctl));
  mpra_properties u_mpra_properties (.CORE_CLK(core_clk), .RESET(reset), .cmd_vld(link.cmd_vld),
    .cmd(link.cmd), .addr(link.addr), .ba(link.ba), .dbi_en(link.dbi_en), .dq_vld(link.dq_vld),
    .dq_last(link.dq_last));
  // free running command clock
  initial forever #10 core_clk = ~core_clk;
  // array reads seen by the device, with auto precharge
  always @(posedge core_clk) begin
    if (array_rd === 1'b1) arr_hits++;
    if (array_rd === 1'b1 && array_ap === 1'b1) ap_hits++;
  end
  task automatic conclude;
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      conclude();
    end
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // link command through the controller, then wait for busy and refresh wait to clear
  task automatic send(input mpra_cmd_t c, input logic [17:0] a, input logic [1:0] b, input logic [7:0] w);
    int n;
    apb(1'b1, MPRA_OFF_ADDR, {w, 2'h0, b, 2'h0, a});
    apb(1'b1, MPRA_OFF_CMD, {28'h0, c});
    for (n = 0; n < 40; n++) begin
      apb(1'b0, MPRA_OFF_STAT, 32'h0);
      if (rd[1] === 1'b0 && rd[3] === 1'b0) break;
    end
    if (n == 40) begin
      mismatches++;
      conclude();
    end
  endtask : send
  task automatic rdm(input logic [1:0] loc, input logic [2:0] bl, input mpra_cmd_t c);
    send(c, {15'h0, bl}, loc, 8'h00);
    apb(1'b0, MPRA_OFF_RDATA, 32'h0);
  endtask : rdm
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, MPRA_OFF_STAT, 32'h0);
    check(rd, MPRA_REG_RESET);
    apb(1'b0, 8'h10, 32'h0);
    check(err_q, 1'b1);
    send(MPRA_CMD_MRS, 18'h00004, 2'h3, 8'h00);
    check(mode_on, 1'b1);
    // every location of page 0, plain and auto precharge reads
    for (int i = 0; i < 4; i++) begin
      rdm(i[1:0], MPRA_BL8_CODE, i[0] ? MPRA_CMD_RDA : MPRA_CMD_RD);
      check(rd[7:0], p0[i]);
    end
    rdm(2'h0, MPRA_BC4_CODE, MPRA_CMD_RD);
    // chop four shifts only the upper nibble over the previous zero byte
    check(rd[7:0], {4'h0, MPRA_P0_L0[7:4]});
    send(MPRA_CMD_MRS, 18'h00804, 2'h3, 8'h00);
    rdm(2'h1, MPRA_BL8_CODE, MPRA_CMD_RD);
    check(rd[7:0], p0[1]);
    send(MPRA_CMD_MRS, 18'h00805, 2'h3, 8'h00);
    send(MPRA_CMD_WR, 18'h00000, 2'h0, 8'h99);
    rdm(2'h0, MPRA_BL8_CODE, MPRA_CMD_RD);
    check(rd[7:0], par_log[0]);
    send(MPRA_CMD_MRS, 18'h00007, 2'h3, 8'h00);
    rdm(2'h2, MPRA_BL8_CODE, MPRA_CMD_RD);
    check(rd[7:0], 8'h00);
    send(MPRA_CMD_MRS, 18'h00004, 2'h3, 8'h00);
    send(MPRA_CMD_WRA, 18'h00000, 2'h2, 8'hA6);
    rdm(2'h2, MPRA_BL8_CODE, MPRA_CMD_RDA);
    check(rd[7:0], 8'hA6);
    // refused commands leave the link quiet and flag an error
    for (int i = 0; i < 4; i++) begin
      send(i[1] ? (i[0] ? MPRA_CMD_PDE : MPRA_CMD_SRE) : (i[0] ? MPRA_CMD_PRE : MPRA_CMD_ACT), 18'h0, 2'h0, 8'h00);
      check(rd[2], 1'b1);
    end
    send(MPRA_CMD_REF, 18'h00000, 2'h0, 8'h00);
    rdm(2'h0, MPRA_BL8_CODE, MPRA_CMD_RD);
    check(rd[7:0], p0[0]);
    check(arr_hits, 0);
    // page 2 lower half of mode register 3, which holds the page select itself
    send(MPRA_CMD_MRS, 18'h00006, 2'h3, 8'h00);
    rdm(2'h3, MPRA_BL8_CODE, MPRA_CMD_RD);
    check(rd[7:0], 8'h06);
    send(MPRA_CMD_MRS, 18'h00000, 2'h3, 8'h00);
    check(mode_on, 1'b0);
    send(MPRA_CMD_RDA, 18'h00000, 2'h0, 8'h00);
    check(ap_hits, 1);
    // reset in mid run wipes the written pattern
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check(mode_on, 1'b0);
    send(MPRA_CMD_MRS, 18'h00004, 2'h3, 8'h00);
    rdm(2'h2, MPRA_BL8_CODE, MPRA_CMD_RD);
    check(rd[7:0], p0[2]);
    conclude();
  end
endmodule : tb_top
